// ==== common/aapc_consts.svh ====
// Offsets, field positions, reset values and timing counts of the
// channel and power configuration registers.
// Assumes a 100 MHz device clock and an 8-bit register map.
`ifndef AAPC_CONSTS_SVH
`define AAPC_CONSTS_SVH

// Register offsets
`define AAPC_OFS_GAIN_UPDATE 8'h71
`define AAPC_OFS_INPUT_EN 8'h73
`define AAPC_OFS_SLOT_EN 8'h74
`define AAPC_OFS_POWER 8'h75
`define AAPC_OFS_STATUS0 8'h76
`define AAPC_OFS_STATUS1 8'h77

// Reset values
`define AAPC_RST_GAIN_UPDATE 8'h00
`define AAPC_RST_INPUT_EN 8'hc0
`define AAPC_RST_SLOT_EN 8'h00
`define AAPC_RST_POWER 8'h00

// Writable bit masks; the rest are read-only zero
`define AAPC_MASK_GAIN_UPDATE 8'he0
`define AAPC_MASK_CHAN_EN 8'hf0
`define AAPC_MASK_POWER 8'hff

// Field positions
`define AAPC_GAIN_SEL_HI 7
`define AAPC_GAIN_SEL_LO 6
`define AAPC_CHAN_HI 7
`define AAPC_CHAN_LO 4
`define AAPC_PWR_MIC_BIAS 7
`define AAPC_PWR_CONVERTER 6
`define AAPC_PWR_SYNTH 5
`define AAPC_PWR_LIVE 4
`define AAPC_PWR_SPAN_HI 3
`define AAPC_PWR_SPAN_LO 2
`define AAPC_PWR_VOICE 0

// Mode report codes
`define AAPC_MODE_SLEEP 3'h4
`define AAPC_MODE_IDLE 3'h6
`define AAPC_MODE_ACTIVE 3'h7

// Gain ramp timing
`define AAPC_CLK_PERIOD_NS 10
`define AAPC_RAMP_FAST_US 20
`define AAPC_RAMP_SLOW_US 40
`define AAPC_RAMP_FAST_CYC ((`AAPC_RAMP_FAST_US * 1000) / `AAPC_CLK_PERIOD_NS)
`define AAPC_RAMP_SLOW_CYC ((`AAPC_RAMP_SLOW_US * 1000) / `AAPC_CLK_PERIOD_NS)

`endif

// ==== common/aapc_pkg.sv ====
// Types shared by the register bank and its two-wire control port.
// Assumes aapc_consts.svh supplies the numeric constants.
package aapc_pkg;

  // Live gain update selection
  typedef enum logic [1:0] {
    AAPC_GAIN_AT_ONCE = 2'h0,
    AAPC_GAIN_AT_SAMPLE = 2'h1,
    AAPC_GAIN_RAMP_FAST = 2'h2,
    AAPC_GAIN_RAMP_SLOW = 2'h3
  } aapc_gain_mode_e;

  // Channel gain code in 0.5 dB units
  typedef logic [6:0] aapc_gain_t;
  typedef logic [3:0][6:0] aapc_gain_vec_t;

  // One register write from the control port
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } aapc_wr_s;

  // Power controls towards the analog blocks
  typedef struct packed {
    logic mic_bias_power_on;
    logic synth_loop_power_on;
    logic voice_detect_on;
    logic [3:0] converter_power_on;
  } aapc_pwr_s;

endpackage

// ==== hdl/aapc_ctrl_port.sv ====
// Two-wire control port slave: device address, register pointer,
// auto-incrementing writes and reads.
// Assumes scl_i and sda_i are already synchronous to clk_i.
`timescale 1ns/1ps

module aapc_ctrl_port #(
  parameter logic [6:0] DEV_ADDR = 7'h4e // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output aapc_pkg::aapc_wr_s wr_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_PTR, ST_PTR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } aapc_port_e;

  aapc_port_e state;
  logic scl_q;
  logic sda_q;
  logic [7:0] shreg;
  logic [3:0] cnt;
  logic [7:0] ptr;
  logic rd_mode;
  logic acked;
  logic drive_low;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  //////////////////////////////////////////////////////////////////////////
  // Line events
  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_c = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_c = scl_i & scl_q & ~sda_q & sda_i;
  assign rd_addr_o = ptr;
  assign sda_o = 1'b0; // Open drain: only ever pulls low
  assign sda_oe_o = drive_low;

  // Previous line levels for edge detection
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Protocol sequencer; bits sampled on rising clock, driven on falling
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      cnt <= 4'h0;
      ptr <= 8'h00;
      rd_mode <= 1'b0;
      acked <= 1'b0;
      drive_low <= 1'b0;
      wr_o <= '0;
    end else begin
      wr_o.valid <= 1'b0;
      if (start_c) begin
        state <= ST_DEV;
        cnt <= 4'h0;
        drive_low <= 1'b0;
      end else if (stop_c) begin
        state <= ST_IDLE;
        drive_low <= 1'b0;
      end else if (scl_rise) begin
        if (state == ST_RD_ACK) begin
          acked <= ~sda_i;
        end else if (state != ST_RD) begin
          shreg <= {shreg[6:0], sda_i};
          cnt <= cnt + 4'h1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else if (scl_fall) begin
        unique case (state)
          ST_IDLE: begin
            drive_low <= 1'b0;
          end
          ST_DEV: begin
            if (cnt == 4'h8) begin
              if (shreg[7:1] == DEV_ADDR) begin
                state <= ST_DEV_ACK;
                rd_mode <= shreg[0];
                drive_low <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_DEV_ACK, ST_PTR_ACK, ST_WR_ACK: begin
            cnt <= 4'h0;
            if (state == ST_WR_ACK) begin
              ptr <= ptr + 8'h01; // Auto-increment after each write
            end
            if (state == ST_DEV_ACK && rd_mode) begin
              state <= ST_RD;
              shreg <= {rd_data_i[6:0], 1'b0};
              drive_low <= ~rd_data_i[7];
            end else begin
              state <= (state == ST_DEV_ACK) ? ST_PTR : ST_WR;
              drive_low <= 1'b0;
            end
          end
          ST_PTR: begin
            if (cnt == 4'h8) begin
              ptr <= shreg;
              state <= ST_PTR_ACK;
              drive_low <= 1'b1;
            end
          end
          ST_WR: begin
            if (cnt == 4'h8) begin
              wr_o.valid <= 1'b1;
              wr_o.addr <= ptr;
              wr_o.data <= shreg;
              state <= ST_WR_ACK;
              drive_low <= 1'b1;
            end
          end
          ST_RD: begin
            if (cnt == 4'h8) begin
              state <= ST_RD_ACK;
              ptr <= ptr + 8'h01; // Next register is ready if the master acks
              drive_low <= 1'b0; // Release for the master's acknowledge
            end else begin
              drive_low <= ~shreg[7];
              shreg <= {shreg[6:0], 1'b0};
            end
          end
          ST_RD_ACK: begin
            cnt <= 4'h0;
            if (acked) begin
              // Continued read: first bit of the next register goes out now
              state <= ST_RD;
              shreg <= {rd_data_i[6:0], 1'b0};
              drive_low <= ~rd_data_i[7];
            end else begin
              state <= ST_IDLE;
              drive_low <= 1'b0;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // aapc_ctrl_port

// ==== hdl/aapc_top.sv ====
// Channel gain update, input and output slot enable and power
// configuration registers, reached over the two-wire control port.
// Assumes channel gain targets, the sample tick, the serial slot
// strobes and the sleep request come from the rest of the converter.
//
// Notes on behaviour
// - Update mode 0 applies a new channel gain immediately, no smoothing.
// - Update mode 1 applies gain without stepping, at a sample boundary.
// - Update mode 2 ramps gain in 0.5 dB steps every 20 us.
// - Update mode 3 ramps gain in 0.5 dB steps every 40 us.
// - Input enables for channels one and two reset set.
// - Input enables for digital-only channels three and four reset clear.
// - A clear slot enable keeps that channel's serial slot undriven.
// - A set slot enable drives the channel's data in its slot.
// - Slot enables reset to zero, all slots undriven.
// - Power bit 7 powers the microphone bias supply; resets off.
// - Power bit 6 powers enabled converter channels; clear powers all down.
// - Power bit 5 powers the frequency synthesizer; resets off.
// - Live power mode lets channels power up or down individually.
// - Span 0 covers channels one and two, span 1 all four.
// - Power bit 0 turns voice activity detection on; resets off.
// - Low reserved bit groups read zero, except gain update bit 5 and power bit 1, which are stored.
// - Channels one and two each report power state in status bits.
// - Mode report: 4 asleep, 6 active all off, 7 some on.
`timescale 1ns/1ps
`include "aapc_consts.svh"

module aapc_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire aapc_pkg::aapc_gain_vec_t gain_target_i,
  input wire logic sample_tick_i,
  output aapc_pkg::aapc_gain_vec_t gain_applied_o,
  input wire logic [3:0] slot_active_i,
  input wire logic [3:0] chan_bit_i,
  output logic sdout_o,
  output logic sdout_oe_o,
  input wire logic sleep_i,
  output aapc_pkg::aapc_pwr_s pwr_o
);

  // Ramp interval counter width covers the slow interval
  localparam logic [11:0] RAMP_FAST_LAST = 12'(`AAPC_RAMP_FAST_CYC - 1);
  localparam logic [11:0] RAMP_SLOW_LAST = 12'(`AAPC_RAMP_SLOW_CYC - 1);

  aapc_pkg::aapc_wr_s wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  logic [7:0] gain_update;
  logic [7:0] input_en;
  logic [7:0] slot_en;
  logic [7:0] power;

  aapc_pkg::aapc_gain_mode_e gain_mode;
  logic [11:0] ramp_cnt;
  logic ramp_tick;
  logic [3:0] chan_en;
  logic [3:0] slot_drive;
  logic [3:0] chan_pwr;
  logic [3:0] live_mask;
  logic conv_q;
  logic [2:0] mode_report;
  logic [7:0] status0;
  logic [7:0] status1;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  // Moves a gain code one 0.5 dB step towards its target
  function automatic aapc_pkg::aapc_gain_t step_toward(
    input aapc_pkg::aapc_gain_t cur,
    input aapc_pkg::aapc_gain_t tgt
  );
    aapc_pkg::aapc_gain_t res;
    res = cur;
    if (cur < tgt) begin
      res = cur + 7'h01;
    end else if (cur > tgt) begin
      res = cur - 7'h01;
    end
    return res;
  endfunction

  // Write of one register, keeping read-only bits at zero
  function automatic logic [7:0] masked_write(
    input logic [7:0] data,
    input logic [7:0] mask
  );
    return data & mask;
  endfunction

  // Field bit 7 is channel one; the result has channel one at index 0
  function automatic logic [3:0] chan_order(input logic [7:0] field);
    return {field[4], field[5], field[6], field[7]};
  endfunction

  // Register read decode; unmapped offsets read zero
  function automatic logic [7:0] reg_read(
    input logic [7:0] addr,
    input logic [7:0] g,
    input logic [7:0] ie,
    input logic [7:0] se,
    input logic [7:0] pw,
    input logic [7:0] s0,
    input logic [7:0] s1
  );
    logic [7:0] res;
    res = 8'h00;
    unique case (addr)
      `AAPC_OFS_GAIN_UPDATE: res = g;
      `AAPC_OFS_INPUT_EN: res = ie;
      `AAPC_OFS_SLOT_EN: res = se;
      `AAPC_OFS_POWER: res = pw;
      `AAPC_OFS_STATUS0: res = s0;
      `AAPC_OFS_STATUS1: res = s1;
      default: res = 8'h00;
    endcase
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Control port

  aapc_ctrl_port u_ctrl_port (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .wr_o(wr),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Gain update register; bits 4-0 are not stored so they read zero
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      gain_update <= `AAPC_RST_GAIN_UPDATE;
    end else if (wr.valid && wr.addr == `AAPC_OFS_GAIN_UPDATE) begin
      gain_update <= masked_write(wr.data, `AAPC_MASK_GAIN_UPDATE);
    end
  end

  // Input channel enables; one and two come up enabled
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      input_en <= `AAPC_RST_INPUT_EN;
    end else if (wr.valid && wr.addr == `AAPC_OFS_INPUT_EN) begin
      input_en <= masked_write(wr.data, `AAPC_MASK_CHAN_EN);
    end
  end

  // Output slot enables; every slot undriven after reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      slot_en <= `AAPC_RST_SLOT_EN;
    end else if (wr.valid && wr.addr == `AAPC_OFS_SLOT_EN) begin
      slot_en <= masked_write(wr.data, `AAPC_MASK_CHAN_EN);
    end
  end

  // Power configuration; reserved bit 1 is stored as written
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      power <= `AAPC_RST_POWER;
    end else if (wr.valid && wr.addr == `AAPC_OFS_POWER) begin
      power <= masked_write(wr.data, `AAPC_MASK_POWER);
    end
  end

  // Read data reflects the latest stored values and live status
  assign rd_data = reg_read(rd_addr, gain_update, input_en, slot_en, power,
                            status0, status1);

  //////////////////////////////////////////////////////////////////////////
  // Live gain update

  assign gain_mode = aapc_pkg::aapc_gain_mode_e'(
    gain_update[`AAPC_GAIN_SEL_HI:`AAPC_GAIN_SEL_LO]);

  // Interval timer for the ramped modes; held cleared otherwise
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ramp_cnt <= 12'h000;
    end else if (ramp_tick) begin
      ramp_cnt <= 12'h000;
    end else if (gain_mode == aapc_pkg::AAPC_GAIN_RAMP_FAST ||
                 gain_mode == aapc_pkg::AAPC_GAIN_RAMP_SLOW) begin
      ramp_cnt <= ramp_cnt + 12'h001;
    end else begin
      ramp_cnt <= 12'h000;
    end
  end

  // One step per interval: 20 us in the fast mode, 40 us in the slow one
  always_comb begin
    ramp_tick = 1'b0;
    unique case (gain_mode)
      aapc_pkg::AAPC_GAIN_RAMP_FAST: ramp_tick = (ramp_cnt >= RAMP_FAST_LAST);
      aapc_pkg::AAPC_GAIN_RAMP_SLOW: ramp_tick = (ramp_cnt >= RAMP_SLOW_LAST);
      default: ramp_tick = 1'b0;
    endcase
  end

  // Applied gain per channel; the limits on ramped gain are the host's to keep
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      gain_applied_o <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        unique case (gain_mode)
          aapc_pkg::AAPC_GAIN_AT_ONCE: begin
            gain_applied_o[i] <= gain_target_i[i];
          end
          aapc_pkg::AAPC_GAIN_AT_SAMPLE: begin
            // Whole jump, but only between samples to soften the step
            if (sample_tick_i) begin
              gain_applied_o[i] <= gain_target_i[i];
            end
          end
          aapc_pkg::AAPC_GAIN_RAMP_FAST, aapc_pkg::AAPC_GAIN_RAMP_SLOW: begin
            if (ramp_tick) begin
              gain_applied_o[i] <= step_toward(gain_applied_o[i], gain_target_i[i]);
            end
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial output slots

  // Slot strobes count from channel one, so the enable field is turned round
  assign slot_drive = chan_order(slot_en);

  // Data and drive both registered so they change together at slot edges
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sdout_o <= 1'b0;
      sdout_oe_o <= 1'b0;
    end else begin
      sdout_o <= |(slot_active_i & slot_drive & chan_bit_i);
      sdout_oe_o <= |(slot_active_i & slot_drive);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Channel power

  // Bit 7 of the enable field is channel one; index 0 here is channel one
  assign chan_en = chan_order(input_en);

  // Channels that may follow their enables live; span codes 2 and 3 act as 0
  assign live_mask = (power[`AAPC_PWR_SPAN_HI:`AAPC_PWR_SPAN_LO] == 2'h1) ?
                     4'hf : 4'h3;

  // Previous converter power bit, to catch the power-up edge
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      conv_q <= 1'b0;
    end else begin
      conv_q <= power[`AAPC_PWR_CONVERTER];
    end
  end

  // Channel set is taken at power-up; afterwards it only moves in live mode.
  // Outside live mode, enable changes while recording are held off until the
  // next power cycle, which protects channels that are still recording.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      chan_pwr <= 4'h0;
    end else if (!power[`AAPC_PWR_CONVERTER]) begin
      chan_pwr <= 4'h0;
    end else if (!conv_q) begin
      chan_pwr <= chan_en;
    end else if (power[`AAPC_PWR_LIVE]) begin
      for (int i = 0; i < 4; i++) begin
        if (live_mask[i]) begin
          chan_pwr[i] <= chan_en[i];
        end
      end
    end
  end

  // Power controls towards the analog side
  always_comb begin
    pwr_o.mic_bias_power_on = power[`AAPC_PWR_MIC_BIAS];
    pwr_o.synth_loop_power_on = power[`AAPC_PWR_SYNTH];
    pwr_o.voice_detect_on = power[`AAPC_PWR_VOICE];
    pwr_o.converter_power_on = chan_pwr;
  end

  //////////////////////////////////////////////////////////////////////////
  // Status

  // Mode report follows sleep first, then whether any channel runs
  always_comb begin
    if (sleep_i) begin
      mode_report = `AAPC_MODE_SLEEP;
    end else if (|chan_pwr) begin
      mode_report = `AAPC_MODE_ACTIVE;
    end else begin
      mode_report = `AAPC_MODE_IDLE;
    end
  end

  assign status0 = {chan_pwr[0], chan_pwr[1], 6'h00};
  assign status1 = {mode_report, 5'h00};

endmodule // aapc_top

// ==== dv/aapc_top_sva.sv ====
// Checker for the channel and power configuration block.
// Assumes it sees only the top ports, bound below.
`timescale 1ns/1ps

module aapc_top_sva (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire aapc_pkg::aapc_gain_vec_t gain_target_i,
  input wire logic sample_tick_i,
  input wire aapc_pkg::aapc_gain_vec_t gain_applied_o,
  input wire logic [3:0] slot_active_i,
  input wire logic [3:0] chan_bit_i,
  input wire logic sdout_o,
  input wire logic sdout_oe_o,
  input wire logic sleep_i,
  input wire aapc_pkg::aapc_pwr_s pwr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  ////////////////////////////////////////
  // Gain already at a steady target must not drift
  sequence s_gain_settled;
    $stable(gain_target_i) && gain_applied_o == gain_target_i;
  endsequence
  // Bus line changes are only legal while the bus clock is low
  sequence s_sda_edge;
    $rose(sda_oe_o) || $fell(sda_oe_o);
  endsequence

  ////////////////////////////////////////
  chk_reset_all_off: assert property ($rose(rstn_i) |-> pwr_o == '0 && !sdout_oe_o
    && gain_applied_o == '0) else $error("outputs not at reset values");
  chk_gain_hold: assert property (s_gain_settled |=> $stable(gain_applied_o))
    else $error("gain moved away from a steady target");
  chk_slot_idle: assert property (slot_active_i == 4'h0 |=> !sdout_oe_o && !sdout_o)
    else $error("serial slot driven with no slot current");
  chk_sdout_zero: assert property (chan_bit_i == 4'h0 |=> !sdout_o)
    else $error("serial data high with all channel bits low");
  chk_sdout_needs_oe: assert property (sdout_o |-> sdout_oe_o)
    else $error("serial data high while slot undriven");
  chk_sda_open_drain: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  chk_sda_scl_low: assert property (s_sda_edge |-> !scl_i)
    else $error("data line changed while bus clock high");
  chk_power_scl_low: assert property ($changed(pwr_o) |-> !scl_i)
    else $error("power outputs changed outside a write");
endmodule // aapc_top_sva

bind aapc_top aapc_top_sva u_sva (.*);

// ==== dv/aapc_host_model.sv ====
// Host model: bus master of the two-wire control port.
// Assumes sda_i is the wired level of the pulled-up data line.
`timescale 1ns/1ps

module aapc_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // Bus idles released, clock high
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  ////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Clock low four cycles so a registered ack settles before the rise
  task automatic bit_io(input logic b, output logic s);
    sda_oe_o <= !b;
    step(2);
    scl_o <= 1'b1;
    step(3);
    s = sda_i;
    step(1);
    scl_o <= 1'b0;
    step(2);
  endtask
  task automatic start_cond();
    sda_oe_o <= 1'b0;
    step(2);
    scl_o <= 1'b1;
    step(4);
    sda_oe_o <= 1'b1;
    step(4);
    scl_o <= 1'b0;
    step(2);
  endtask
  task automatic stop_cond();
    sda_oe_o <= 1'b1;
    step(2);
    scl_o <= 1'b1;
    step(4);
    sda_oe_o <= 1'b0;
    step(4);
  endtask
  // Byte MSB first, then the ack bit
  task automatic byte_io(input logic [7:0] tx, input logic last,
                         output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(last, s);
    ack = !s;
  endtask

  ////////////////////////////////////////
  // Gain update bit 5, power bit 1 and span codes 2 and 3 are never sent
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] val, output logic ok);
    logic [7:0] rx;
    logic [7:0] v;
    logic a0, a1, a2;
    v = val & ((ofs == 8'h71) ? 8'hdf : (ofs == 8'h75) ? 8'hf5 : 8'hff);
    start_cond();
    byte_io({dev, 1'b0}, 1'b1, rx, a0);
    byte_io(ofs, 1'b1, rx, a1);
    byte_io(v, 1'b1, rx, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  // With more set the master acks the first byte and reads the next one too
  task automatic read_reg(input logic [7:0] ofs, input logic more,
                          output logic [15:0] val);
    logic [7:0] rx;
    logic a;
    val = 16'h0000;
    start_cond();
    byte_io({7'h4e, 1'b0}, 1'b1, rx, a);
    byte_io(ofs, 1'b1, rx, a);
    start_cond();
    byte_io({7'h4e, 1'b1}, 1'b1, rx, a);
    byte_io(8'hff, !more, val[15:8], a);
    if (more) begin
      byte_io(8'hff, 1'b1, val[7:0], a);
    end
    stop_cond();
  endtask
endmodule // aapc_host_model

// ==== dv/audio_adc_channel_power_cfg_test.sv ====
// Self-checking bench for the configuration register block.
// Assumes the host model speaks the two-wire port, device address 7'h4e.
`timescale 1ns/1ps

module audio_adc_channel_power_cfg_test;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic scl, host_oe, sda_oe, sda_o, sdout, sdout_oe;
  logic sample_tick = 1'b0;
  logic sleep = 1'b0;
  logic [3:0] slot_active = 4'h0;
  logic [3:0] chan_bit = 4'h0;
  aapc_pkg::aapc_gain_vec_t gain_target = '0;
  aapc_pkg::aapc_gain_vec_t gain_applied;
  aapc_pkg::aapc_pwr_s pwr;
  wire logic sda_w = !(host_oe | sda_oe);
  int fails = 0;
  int n_compared = 0;

  always #5 clk_i = !clk_i;

  aapc_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .gain_target_i(gain_target),
    .sample_tick_i(sample_tick), .gain_applied_o(gain_applied),
    .slot_active_i(slot_active), .chan_bit_i(chan_bit), .sdout_o(sdout),
    .sdout_oe_o(sdout_oe), .sleep_i(sleep), .pwr_o(pwr));
  aapc_host_model host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(host_oe));

  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    logic a;
    host.write_reg(7'h4e, ofs, v, a);
    check("ack", a, 1'b1);
  endtask
  task automatic rdc(input logic [7:0] ofs, input logic [7:0] want);
    logic [15:0] v;
    host.read_reg(ofs, 1'b0, v);
    check($sformatf("reg %h", ofs), v[15:8], want);
  endtask
  // Value a register keeps after a write: low reserved groups read zero
  function automatic logic [7:0] stored(input logic [7:0] ofs, input logic [7:0] v);
    return v & ((ofs == 8'h71) ? 8'hc0 : 8'hf0);
  endfunction

  // Watchdog sized well above the longest expected run
  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    finish_test();
  end

  ////////////////////////////////////////
  initial begin
    logic [7:0] v, en, bits;
    logic [6:0] t, u;
    logic a;
    logic [15:0] w;
    logic [7:0] ofs_list [3];
    ofs_list = '{8'h71, 8'h73, 8'h74};
    void'($urandom(32'h3b6383c2));
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    // Reset values and mode report with all channels off
    rdc(8'h71, 8'h00);
    rdc(8'h73, 8'hc0);
    rdc(8'h74, 8'h00);
    rdc(8'h75, 8'h00);
    rdc(8'h76, 8'h00);
    rdc(8'h77, 8'hc0);
    // Random write and read back; low reserved bits stay zero
    foreach (ofs_list[i]) begin
      v = 8'($urandom());
      wr(ofs_list[i], v);
      rdc(ofs_list[i], stored(ofs_list[i], v));
    end
    host.write_reg(7'h4e, 8'h72, 8'hff, a);
    rdc(8'h72, 8'h00);
    // Slot drive, each channel enabled once and disabled once
    en = 8'($urandom());
    for (int k = 0; k < 2; k++) begin
      en = ~en;
      wr(8'h74, en);
      for (int c = 0; c < 4; c++) begin
        bits = 8'($urandom());
        slot_active <= 4'h1 << c;
        chan_bit <= bits[3:0];
        repeat (2) @(posedge clk_i);
        check("slot oe", sdout_oe, en[7 - c]);
        check("slot data", sdout, en[7 - c] & bits[c]);
      end
      slot_active <= 4'h0;
    end
    host.write_reg(7'h4f, 8'h74, ~en, a);
    check("foreign nack", a, 1'b0);
    rdc(8'h74, en & 8'hf0);
    // Power controls, status and mode report
    wr(8'h73, 8'h80);
    wr(8'h75, 8'he1);
    check("pwr on", pwr, {3'b111, 4'h1});
    rdc(8'h76, 8'h80);
    rdc(8'h77, 8'he0);
    host.read_reg(8'h76, 1'b1, w);
    check("two byte read", w, 16'h80e0);
    sleep <= 1'b1;
    rdc(8'h77, 8'h80);
    sleep <= 1'b0;
    wr(8'h75, 8'h00);
    check("pwr off", pwr, 7'h00);
    // Live per-channel power, span four then span two
    wr(8'h75, 8'h54);
    wr(8'h73, 8'hf0);
    check("live four", pwr.converter_power_on, 4'hf);
    wr(8'h73, 8'h40);
    check("live one off", pwr.converter_power_on, 4'h2);
    wr(8'h75, 8'h50);
    wr(8'h73, 8'hc0);
    check("live two", pwr.converter_power_on[1:0], 2'h3);
    wr(8'h75, 8'h00);
    // Gain update modes; ramp targets stay at or below 48 codes
    wr(8'h71, 8'h00);
    t = 7'($urandom_range(0, 43));
    u = t ^ 7'h01;
    gain_target <= {4{t}};
    repeat (2) @(posedge clk_i);
    check("gain now", gain_applied, {4{t}});
    wr(8'h71, 8'h40);
    gain_target <= {4{u}};
    repeat (5) @(posedge clk_i);
    check("gain wait", gain_applied, {4{t}});
    sample_tick <= 1'b1;
    @(posedge clk_i);
    sample_tick <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("gain tick", gain_applied, {4{u}});
    wr(8'h71, 8'h80);
    gain_target <= {4{u + 7'h02}};
    repeat (1000) @(posedge clk_i);
    check("ramp2 early", gain_applied == {4{u + 7'h02}}, 1'b0);
    repeat (3100) @(posedge clk_i);
    check("ramp2 done", gain_applied, {4{u + 7'h02}});
    wr(8'h71, 8'hc0);
    gain_target <= {4{u + 7'h04}};
    repeat (2000) @(posedge clk_i);
    check("ramp3 early", gain_applied == {4{u + 7'h04}}, 1'b0);
    repeat (6100) @(posedge clk_i);
    check("ramp3 done", gain_applied, {4{u + 7'h04}});
    finish_test();
  end
endmodule // audio_adc_channel_power_cfg_test
